// ===== rtl/rsc_map.svh
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// instruction field positions
`define RSC_OP_LSB      12
`define RSC_RN_LSB      8
`define RSC_RM_LSB      4

// program counter values
`define RSC_RESET_PC    32'h00000000
`define RSC_INSN_STEP   32'h00000002
`define RSC_PC_AHEAD    32'h00000004
`define RSC_LONG_MASK   32'hFFFFFFFC

// multiplier busy cycles after the issue cycle
`define RSC_MUL16_CYC   2'h1
`define RSC_MAC16_CYC   2'h2
`define RSC_MUL32_CYC   2'h2
`define RSC_MAC32_CYC   2'h3

`endif

// ===== rtl/rsc_pkg.sv
package rsc_pkg;

    // opcode in bits 15:12
    typedef enum logic [3:0] {
        OP_NOP                   = 4'h0,
        OP_ADD                   = 4'h1,
        OP_ADD_IMM               = 4'h2,
        OP_LOAD_IMM              = 4'h3,
        OP_AND_IMM               = 4'h4,
        OP_OR_IMM                = 4'h5,
        OP_COMPARE_EQUAL         = 4'h6,
        OP_COMPARE_GREATER_EQUAL = 4'h7,
        OP_ALWAYS_JUMP_DELAYED   = 4'h8,
        OP_JUMP_COND             = 4'h9,
        OP_LOAD_STORE            = 4'hA,
        OP_TRANSFER_LIT_WORD     = 4'hB,
        OP_TRANSFER_LIT_LONG     = 4'hC,
        OP_BIT_MEMORY            = 4'hD,
        OP_MULTIPLY              = 4'hE,
        OP_SPARE                 = 4'hF
    } rsc_op_t;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2,
        SZ_RSVD = 2'h3
    } rsc_size_t;

    typedef enum logic [1:0] {
        MF_MUL16 = 2'h0,
        MF_MAC16 = 2'h1,
        MF_MUL32 = 2'h2,
        MF_MAC32 = 2'h3
    } rsc_mfn_t;

    typedef enum logic [1:0] {
        ST_EXEC = 2'b00,
        ST_MEM  = 2'b01,
        ST_RMW  = 2'b10,
        ST_MUL  = 2'b11
    } rsc_state_t;

endpackage : rsc_pkg

// ===== rtl/rsc_load_ext.sv
`timescale 1ns/1ns
module rsc_load_ext
    import rsc_pkg::*;
(
    input  wire rsc_size_t   i_size,
    input  wire logic [1:0]  i_addr_lo,
    input  wire logic [31:0] i_raw,
    output logic [31:0]      o_data,
    output logic             o_misalign
);

    // narrow loads widen with their sign bit
    always_comb begin
        case (i_size)
            SZ_BYTE: o_data = {{24{i_raw[7]}}, i_raw[7:0]};
            SZ_WORD: o_data = {{16{i_raw[15]}}, i_raw[15:0]};
            default: o_data = i_raw;
        endcase
    end

    // word needs even, longword needs multiple of four
    assign o_misalign = ((i_size == SZ_WORD) && i_addr_lo[0]) ||
                        ((i_size == SZ_LONG) && (i_addr_lo != 2'b00));

endmodule : rsc_load_ext

// ===== rtl/rsc_mul_unit.sv
`timescale 1ns/1ns
`include "rsc_map.svh"
module rsc_mul_unit
    import rsc_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire rsc_mfn_t    i_func,
    input  wire logic [31:0] i_a,
    input  wire logic [31:0] i_b,
    output logic             o_done,
    output logic [31:0]      o_hi,
    output logic [31:0]      o_lo
);

    logic        busy_q;
    logic [1:0]  cnt_q;
    logic [1:0]  lat;
    rsc_mfn_t    fn_q;
    logic [31:0] a_q;
    logic [31:0] b_q;
    logic [31:0] hi_q;
    logic [31:0] lo_q;
    logic signed [31:0] p16;
    logic signed [63:0] p32;
    logic [63:0] acc;

    // busy time per operation kind
    always_comb begin
        case (i_func)
            MF_MUL16: lat = `RSC_MUL16_CYC;
            MF_MAC16: lat = `RSC_MAC16_CYC;
            MF_MUL32: lat = `RSC_MUL32_CYC;
            default:  lat = `RSC_MAC32_CYC;
        endcase
    end

    // operand capture and countdown
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            cnt_q  <= 2'h0;
            fn_q   <= MF_MUL16;
            a_q    <= 32'h00000000;
            b_q    <= 32'h00000000;
        end else if (i_start) begin
            busy_q <= 1'b1;
            cnt_q  <= lat - 2'h1;
            fn_q   <= i_func;
            a_q    <= i_a;
            b_q    <= i_b;
        end else if (busy_q) begin
            if (cnt_q == 2'h0) begin
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end

    assign o_done = busy_q && (cnt_q == 2'h0);
    // operands widened to the product width before the multiply
    assign p16    = 32'($signed(a_q[15:0])) * 32'($signed(b_q[15:0]));
    assign p32    = 64'($signed(a_q)) * 64'($signed(b_q));
    assign acc    = {hi_q, lo_q};

    // product pair written on the final cycle, only lo_q for MF_MUL16
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            hi_q <= 32'h00000000;
            lo_q <= 32'h00000000;
        end else if (o_done) begin
            case (fn_q)
                MF_MUL16: lo_q <= p16;
                MF_MAC16: {hi_q, lo_q} <= acc + {{32{p16[31]}}, p16};
                MF_MUL32: {hi_q, lo_q} <= p32;
                default:  {hi_q, lo_q} <= acc + p32;
            endcase
        end
    end

    assign o_hi = hi_q;
    assign o_lo = lo_q;

endmodule : rsc_mul_unit

// ===== rtl/rsc_core.sv
// Functional notes
// - every instruction is one fixed 16-bit word, decoded whole
// - basic instructions retire at one per clock
// - operations are 32-bit; memory takes byte, word, longword sizes
// - byte and word loads sign-extend to 32 bits
// - arithmetic immediates sign-extend, logical immediates zero-extend
// - unconditional jump runs the next instruction before transferring
// - conditional jumps exist in delayed and immediate forms
// - signed 16x16 to 32 multiply takes one to two cycles
// - 16x16 multiply into 64-bit accumulator takes two to three cycles
// - 32x32 multiply and 32x32 accumulate take two to four cycles
// - compares update the flag; conditional jumps test it
// - jump-if-set needs flag one, jump-if-clear needs flag zero
// - register add leaves the flag alone; few ops touch it
// - 8-bit immediate comes straight from the instruction word
// - word and long constants load pc-relative from a literal table
// - data ops use registers; bit logic ops work on memory
// - misaligned word or longword access raises address error
// - and with 8-bit immediate clears upper 24 destination bits
// - multiply results land in the high and low product registers; the 16x16 multiply writes only the low one
`timescale 1ns/1ns
`include "rsc_map.svh"
module rsc_core
    import rsc_pkg::*;
#(
    parameter logic [31:0] RESET_PC = `RSC_RESET_PC
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    output logic [31:0]      o_fetch_addr,
    input  wire logic [15:0] i_insn,
    input  wire logic        i_insn_valid,
    output logic             o_mem_req,
    output logic             o_mem_we,
    output rsc_size_t        o_mem_size,
    output logic [31:0]      o_mem_addr,
    output logic [31:0]      o_mem_wdata,
    input  wire logic [31:0] i_mem_rdata,
    input  wire logic        i_mem_ack,
    output logic             o_t_flag,
    output logic [31:0]      o_prod_hi,
    output logic [31:0]      o_prod_lo,
    output logic             o_addr_err,
    output logic             o_retire
);

    logic [31:0] rf [16];
    rsc_state_t  st_q;
    logic [31:0] pc_q;
    logic        dly_q;
    logic [31:0] dly_tgt_q;
    logic        t_q;
    logic        retire_q;
    logic        err_q;
    logic [3:0]  ld_dst_q;
    logic        rmw_q;
    logic [1:0]  bfn_q;
    logic [7:0]  bimm_q;

    rsc_op_t     op;
    logic [3:0]  rn;
    logic [3:0]  rm;
    logic [7:0]  imm8;
    logic [31:0] imm_sx;
    logic [31:0] imm_zx;
    logic [31:0] rn_val;
    logic [31:0] rm_val;
    logic [31:0] pc_inc;
    logic [31:0] pc_ahead;
    logic [31:0] jmp12;
    logic [31:0] jmp8;
    logic        taken;
    logic        fire;
    logic        is_mem;
    logic        mis;
    logic        done;
    logic [31:0] acc_addr;
    rsc_size_t   acc_size;
    rsc_size_t   ext_size;
    logic [1:0]  ext_lo;
    logic [31:0] ext_data;
    logic [7:0]  bit_res;
    logic        mul_done;

    // whole-word field split
    assign op     = rsc_op_t'(i_insn[`RSC_OP_LSB +: 4]);
    assign rn     = i_insn[`RSC_RN_LSB +: 4];
    assign rm     = i_insn[`RSC_RM_LSB +: 4];
    assign imm8   = i_insn[7:0];
    assign imm_sx = {{24{imm8[7]}}, imm8};
    assign imm_zx = {24'h000000, imm8};
    assign rn_val = rf[rn];
    assign rm_val = rf[rm];

    // jump targets, displacement counted in instruction steps
    assign pc_inc   = pc_q + `RSC_INSN_STEP;
    assign pc_ahead = pc_q + `RSC_PC_AHEAD;
    assign jmp12    = pc_ahead + {{19{i_insn[11]}}, i_insn[11:0], 1'b0};
    assign jmp8     = pc_ahead + {{23{imm8[7]}}, imm8, 1'b0};
    assign taken    = i_insn[9] ? ~t_q : t_q;

    assign fire   = (st_q == ST_EXEC) && i_insn_valid;
    assign is_mem = (op == OP_LOAD_STORE) || (op == OP_TRANSFER_LIT_WORD) ||
                    (op == OP_TRANSFER_LIT_LONG) || (op == OP_BIT_MEMORY);

    // effective address and size of a memory instruction
    always_comb begin
        case (op)
            OP_LOAD_STORE: begin
                acc_addr = rm_val;
                acc_size = rsc_size_t'(i_insn[1:0]);
            end
            OP_TRANSFER_LIT_WORD: begin
                acc_addr = pc_ahead + {23'h000000, imm8, 1'b0};
                acc_size = SZ_WORD;
            end
            OP_TRANSFER_LIT_LONG: begin
                acc_addr = (pc_q & `RSC_LONG_MASK) + `RSC_PC_AHEAD +
                           {22'h000000, imm8, 2'b00};
                acc_size = SZ_LONG;
            end
            default: begin
                acc_addr = rf[0];
                acc_size = SZ_BYTE;
            end
        endcase
    end

    assign ext_size = (st_q == ST_EXEC) ? acc_size : o_mem_size;
    assign ext_lo   = (st_q == ST_EXEC) ? acc_addr[1:0] : o_mem_addr[1:0];

    rsc_load_ext u_ext (
        .i_size     (ext_size),
        .i_addr_lo  (ext_lo),
        .i_raw      (i_mem_rdata),
        .o_data     (ext_data),
        .o_misalign (mis)
    );

    rsc_mul_unit u_mul (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_start   (fire && (op == OP_MULTIPLY)),
        .i_func    (rsc_mfn_t'(i_insn[1:0])),
        .i_a       (rn_val),
        .i_b       (rm_val),
        .o_done    (mul_done),
        .o_hi      (o_prod_hi),
        .o_lo      (o_prod_lo)
    );

    // read-modify-write byte for memory bit logic
    always_comb begin
        case (bfn_q)
            2'h1:    bit_res = i_mem_rdata[7:0] | bimm_q;
            2'h2:    bit_res = i_mem_rdata[7:0] ^ bimm_q;
            default: bit_res = i_mem_rdata[7:0] & bimm_q;
        endcase
    end

    // instruction completion
    assign done = (fire && !(is_mem && !mis) && (op != OP_MULTIPLY)) ||
                  ((st_q == ST_MEM) && i_mem_ack && !rmw_q) ||
                  ((st_q == ST_RMW) && i_mem_ack) ||
                  ((st_q == ST_MUL) && mul_done);

    // sequencing and data bus requests
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q        <= ST_EXEC;
            o_mem_req   <= 1'b0;
            o_mem_we    <= 1'b0;
            o_mem_size  <= SZ_BYTE;
            o_mem_addr  <= 32'h00000000;
            o_mem_wdata <= 32'h00000000;
            ld_dst_q    <= 4'h0;
            rmw_q       <= 1'b0;
            bfn_q       <= 2'h0;
            bimm_q      <= 8'h00;
        end else begin
            case (st_q)
                ST_EXEC: begin
                    if (fire && is_mem && !mis) begin
                        st_q        <= ST_MEM;
                        o_mem_req   <= 1'b1;
                        o_mem_we    <= (op == OP_LOAD_STORE) && i_insn[2];
                        o_mem_size  <= acc_size;
                        o_mem_addr  <= acc_addr;
                        o_mem_wdata <= rn_val;
                        ld_dst_q    <= rn;
                        rmw_q       <= (op == OP_BIT_MEMORY);
                        bfn_q       <= i_insn[11:10];
                        bimm_q      <= imm8;
                    end else if (fire && (op == OP_MULTIPLY)) begin
                        st_q <= ST_MUL;
                    end
                end
                ST_MEM: begin
                    if (i_mem_ack && rmw_q) begin
                        st_q        <= ST_RMW;
                        o_mem_we    <= 1'b1;
                        o_mem_wdata <= {24'h000000, bit_res};
                    end else if (i_mem_ack) begin
                        st_q      <= ST_EXEC;
                        o_mem_req <= 1'b0;
                    end
                end
                ST_RMW: begin
                    if (i_mem_ack) begin
                        st_q      <= ST_EXEC;
                        o_mem_req <= 1'b0;
                        o_mem_we  <= 1'b0;
                    end
                end
                ST_MUL: begin
                    if (mul_done) begin
                        st_q <= ST_EXEC;
                    end
                end
                default: st_q <= ST_EXEC;
            endcase
        end
    end

    // program counter and pending delayed jump
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pc_q      <= RESET_PC;
            dly_q     <= 1'b0;
            dly_tgt_q <= 32'h00000000;
        end else if (fire && !dly_q && (op == OP_ALWAYS_JUMP_DELAYED)) begin
            pc_q      <= pc_inc;
            dly_q     <= 1'b1;
            dly_tgt_q <= jmp12;
        end else if (fire && !dly_q && (op == OP_JUMP_COND) && taken) begin
            if (i_insn[8]) begin
                pc_q      <= pc_inc;
                dly_q     <= 1'b1;
                dly_tgt_q <= jmp8;
            end else begin
                pc_q <= jmp8;
            end
        end else if (done) begin
            pc_q  <= dly_q ? dly_tgt_q : pc_inc;
            dly_q <= 1'b0;
        end
    end

    // general registers
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < 16; i++) begin
                rf[i] <= 32'h00000000;
            end
        end else if (fire) begin
            case (op)
                OP_ADD:      rf[rn] <= rn_val + rm_val;
                OP_ADD_IMM:  rf[rn] <= rn_val + imm_sx;
                OP_LOAD_IMM: rf[rn] <= imm_sx;
                OP_AND_IMM:  rf[rn] <= rn_val & imm_zx;
                OP_OR_IMM:   rf[rn] <= rn_val | imm_zx;
                default:     ;
            endcase
        end else if ((st_q == ST_MEM) && i_mem_ack && !o_mem_we && !rmw_q) begin
            rf[ld_dst_q] <= ext_data;
        end
    end

    // comparison flag, written by compares only
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            t_q <= 1'b0;
        end else if (fire && (op == OP_COMPARE_EQUAL)) begin
            t_q <= (rn_val == imm_sx);
        end else if (fire && (op == OP_COMPARE_GREATER_EQUAL)) begin
            t_q <= ($signed(rn_val) >= $signed(rm_val));
        end
    end

    // completion and error pulses
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            retire_q <= 1'b0;
            err_q    <= 1'b0;
        end else begin
            retire_q <= done;
            err_q    <= fire && is_mem && mis;
        end
    end

    assign o_fetch_addr = pc_q;
    assign o_t_flag     = t_q;
    assign o_addr_err   = err_q;
    assign o_retire     = retire_q;

    // checking helpers
    logic [3:0]  chk_rn_q;
    logic [31:0] chk_sum_q;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            chk_rn_q  <= 4'h0;
            chk_sum_q <= 32'h00000000;
        end else begin
            chk_rn_q  <= rn;
            chk_sum_q <= rn_val + 32'($signed(i_insn[7:0]));
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    basic_one_cycle_a: assert property (
        fire && (op == OP_ADD) |=> o_retire && (st_q == ST_EXEC))
        else $error("basic op did not retire next cycle");
    add_keeps_flag_a: assert property (
        fire && (op == OP_ADD) |=> $stable(t_q))
        else $error("register add changed the flag");
    compare_equal_flag_a: assert property (
        fire && (op == OP_COMPARE_EQUAL) && (rn_val == imm_sx) |=> t_q)
        else $error("equal compare did not set flag");
    jump_clear_a: assert property (
        fire && !dly_q && (op == OP_JUMP_COND) && i_insn[9] && !i_insn[8] && !t_q
        |=> pc_q == $past(jmp8))
        else $error("jump-if-clear not taken with flag zero");
    delay_slot_a: assert property (
        fire && !dly_q && (op == OP_ALWAYS_JUMP_DELAYED)
        |=> (pc_q == $past(pc_inc)) && dly_q)
        else $error("delayed jump skipped its slot");
    and_upper_zero_a: assert property (
        fire && (op == OP_AND_IMM) |=> rf[chk_rn_q][31:24] == 8'h00)
        else $error("and immediate left upper bits set");
    add_imm_sext_a: assert property (
        fire && (op == OP_ADD_IMM) |=> rf[chk_rn_q] == chk_sum_q)
        else $error("add immediate not sign extended");
    misalign_err_a: assert property (
        fire && is_mem && mis |=> o_addr_err && !o_mem_req)
        else $error("misaligned access not flagged");
    mul16_time_a: assert property (
        fire && (op == OP_MULTIPLY) && (i_insn[1:0] == 2'h0) |-> ##[1:2] o_retire)
        else $error("16-bit multiply too slow");
    mac16_time_a: assert property (
        fire && (op == OP_MULTIPLY) && (i_insn[1:0] == 2'h1) |-> ##[2:3] o_retire)
        else $error("16-bit accumulate too slow");
    mul32_time_a: assert property (
        fire && (op == OP_MULTIPLY) && i_insn[1] |-> ##[2:4] o_retire)
        else $error("32-bit multiply too slow");

    cover property (fire && (op == OP_ALWAYS_JUMP_DELAYED) ##1 fire ##1 o_retire);
    cover property ((st_q == ST_RMW) && i_mem_ack);
    cover property (fire && (op == OP_MULTIPLY) && (i_insn[1:0] == 2'h3));
    cover property (o_addr_err);

endmodule : rsc_core

// ===== verif/rsc_mem_model.sv
`timescale 1ns/1ns
module rsc_mem_model
    import rsc_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic [1:0]  i_delay,
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire rsc_size_t   i_size,
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_wdata,
    output logic [31:0]      o_rdata,
    output logic             o_ack,
    output logic [31:0]      o_last_wdata
);
    logic [7:0] mem_q [0:255];
    logic [1:0] wait_q;
    logic [7:0] a;

    assign a = i_addr[7:0];

    // little-endian preset of one longword
    task automatic put(input logic [7:0] at, input logic [31:0] v);
        for (int k = 0; k < 4; k++) begin
            mem_q[at + 8'(k)] = v[8*k +: 8];
        end
    endtask : put

    // preset load, literal and bit-op bytes
    initial begin
        foreach (mem_q[k]) begin
            mem_q[k] = 8'h00;
        end
        mem_q[0] = 8'h3C;
        put(8'h20, 32'h567892B4);
        put(8'h34, 32'h80010000);
        put(8'h38, 32'h44332211);
    end

    // answer after i_delay waiting edges with one ack pulse
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_q <= 2'h0;
            o_ack <= 1'b0;
            o_rdata <= 32'h00000000;
            o_last_wdata <= 32'h00000000;
        end else if (o_ack) begin
            o_ack <= 1'b0;
            wait_q <= 2'h0;
            o_rdata <= ~o_rdata; // released data does not hold
        end else if (i_req && wait_q != i_delay) begin
            wait_q <= wait_q + 2'h1;
        end else if (i_req) begin
            o_ack <= 1'b1;
            if (i_we) begin
                o_last_wdata <= i_wdata;
                mem_q[a] <= i_wdata[7:0];
                if (i_size != SZ_BYTE) begin
                    mem_q[a + 8'h1] <= i_wdata[15:8];
                end
                if (i_size == SZ_LONG) begin
                    mem_q[a + 8'h2] <= i_wdata[23:16];
                    mem_q[a + 8'h3] <= i_wdata[31:24];
                end
            end
            // upper lanes carry junk for narrow reads
            case (i_size)
                SZ_BYTE: o_rdata <= {24'hC3C3C3, mem_q[a]};
                SZ_WORD: o_rdata <= {16'hC3C3, mem_q[a + 8'h1], mem_q[a]};
                default: o_rdata <= {mem_q[a + 8'h3], mem_q[a + 8'h2], mem_q[a + 8'h1], mem_q[a]};
            endcase
        end
    end
endmodule : rsc_mem_model

// ===== verif/rsc_core_tb.sv
`timescale 1ns/1ns
module rsc_core_tb;
    import rsc_pkg::*;
    typedef struct packed {
        logic [15:0] insn;
        logic        t;
        logic [3:0]  kind;
        logic [3:0]  lat;
        logic [63:0] val;
    } rsc_row_t;
    localparam int NROW = 47;
    logic        i_sys_clk, i_rst, i_insn_valid, mem_req, mem_we, mem_ack, t_flag;
    logic        addr_err, retire, seen_err, seen_req;
    logic [15:0] i_insn;
    logic [1:0]  delay;
    logic [31:0] fetch_addr, mem_addr, mem_wdata, mem_rdata, prod_hi, prod_lo;
    logic [31:0] last_wdata, exp_pc;
    rsc_size_t   mem_size;
    int          bad_count, checks, cycles, n;
    // kind 1 write data, 2 products, 3 address error, 4 jump to val
    rsc_row_t rows [NROW] = '{
        '{16'h3220,0,0,1,0}, '{16'hA522,0,0,0,0}, '{16'hA526,0,1,0,64'h567892B4},
        '{16'hA521,0,0,0,0}, '{16'hA526,0,1,0,64'hFFFF92B4}, '{16'hA520,0,0,0,0},
        '{16'hA526,0,1,0,64'hFFFFFFB4}, '{16'h45F0,0,0,1,0}, '{16'hA526,0,1,0,64'hB0},
        '{16'h550F,0,0,1,0}, '{16'h25FF,0,0,1,0}, '{16'hA526,0,1,0,64'hBE},
        '{16'h3680,0,0,1,0}, '{16'hA626,0,1,0,64'hFFFFFF80}, '{16'h7560,1,0,1,0},
        '{16'h7650,0,0,1,0}, '{16'h7560,1,0,1,0}, '{16'h1560,1,0,1,0},
        '{16'h653F,0,0,1,0}, '{16'h6680,1,0,1,0}, '{16'h6681,0,0,1,0},
        '{16'hB704,0,0,0,0}, '{16'hA726,0,1,0,64'hFFFF8001}, '{16'hC802,0,0,0,0},
        '{16'hA826,0,1,0,64'h44332211}, '{16'hE560,0,2,2,64'hFFFFE100},
        '{16'hE561,0,2,3,64'hFFFFC200}, '{16'hE562,0,2,3,64'hFFFFFFFFFFFFE100},
        '{16'hE563,0,2,4,64'hFFFFFFFFFFFFC200}, '{16'hD0F0,0,1,0,64'h30},
        '{16'hD40F,0,1,0,64'h3F}, '{16'hD8FF,0,1,0,64'hC0}, '{16'hDC80,0,1,0,64'h80},
        '{16'hA571,0,3,0,0}, '{16'hA572,0,3,0,0}, '{16'hA526,0,1,0,64'h3E},
        '{16'h8002,0,0,1,0}, '{16'h1550,0,4,1,64'h50}, '{16'h9002,0,0,1,0},
        '{16'h9202,0,4,0,64'h5A}, '{16'h9302,0,0,0,0}, '{16'h3F01,0,4,0,64'h62},
        '{16'h6400,1,0,1,0}, '{16'h90FC,1,4,0,64'h60}, '{16'h9102,1,0,0,0},
        '{16'h8010,1,4,0,64'h68}, '{16'hA526,1,1,0,64'h7C}};

    rsc_core rsc_core_inst (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_fetch_addr(fetch_addr),
        .i_insn(i_insn), .i_insn_valid(i_insn_valid), .o_mem_req(mem_req),
        .o_mem_we(mem_we), .o_mem_size(mem_size), .o_mem_addr(mem_addr),
        .o_mem_wdata(mem_wdata), .i_mem_rdata(mem_rdata), .i_mem_ack(mem_ack),
        .o_t_flag(t_flag), .o_prod_hi(prod_hi), .o_prod_lo(prod_lo),
        .o_addr_err(addr_err), .o_retire(retire));

    rsc_mem_model rsc_mem_model_inst (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_delay(delay), .i_req(mem_req),
        .i_we(mem_we), .i_size(mem_size), .i_addr(mem_addr), .i_wdata(mem_wdata),
        .o_rdata(mem_rdata), .o_ack(mem_ack), .o_last_wdata(last_wdata));

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // present one word, then wait for its retire pulse
    task automatic step(input logic [15:0] w);
        @(posedge i_sys_clk);
        i_insn <= w;
        i_insn_valid <= 1'b1;
        @(posedge i_sys_clk);
        i_insn_valid <= 1'b0;
        n = 0;
        seen_err = 1'b0;
        seen_req = 1'b0;
        do begin
            @(posedge i_sys_clk);
            n++;
            seen_err |= addr_err;
            seen_req |= mem_req;
        end while (retire !== 1'b1 && n < 40);
        chk("retire", retire, 1'b1);
    endtask : step

    // free-running clock
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    // hang guard
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            summarize();
        end
    end

    // main sequence
    initial begin
        i_rst = 1'b1;
        i_insn = 16'h0000;
        i_insn_valid = 1'b0;
        delay = 2'h0;
        exp_pc = 32'h00000000;
        repeat (16) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
        chk("reset state", {fetch_addr, 29'h0, t_flag, mem_req, retire}, 64'h0);
        chk("reset product", {prod_hi, prod_lo}, 64'h0);
        $display("test reset done");
        for (int i = 0; i < NROW; i++) begin
            delay <= 2'(i % 4); // prompt and slow answers
            step(rows[i].insn);
            chk("t_flag", t_flag, rows[i].t);
            if (rows[i].lat != 0) begin
                chk("latency", 64'(n), 64'(rows[i].lat));
            end
            case (rows[i].kind)
                1: chk("wdata", last_wdata, rows[i].val);
                2: chk("product", {prod_hi, prod_lo}, rows[i].val);
                3: chk("addr_err", {seen_req, seen_err}, 2'b01);
                default: ;
            endcase
            exp_pc = (rows[i].kind == 4) ? rows[i].val[31:0] : exp_pc + 32'h2;
            chk("fetch_addr", fetch_addr, exp_pc);
            $display("test row %0d done", i);
        end
        // three loads taken on consecutive edges
        @(posedge i_sys_clk);
        i_insn <= 16'h3901;
        i_insn_valid <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(posedge i_sys_clk);
            if (i < 2) begin
                i_insn <= 16'h3902 + 16'(i);
            end else begin
                i_insn_valid <= 1'b0;
            end
            if (i > 0) begin
                chk("retire", retire, 1'b1);
            end
        end
        @(posedge i_sys_clk);
        chk("retire", retire, 1'b1);
        step(16'hA926);
        chk("wdata", last_wdata, 64'h3);
        chk("fetch_addr", fetch_addr, exp_pc + 32'h8);
        $display("test back to back done");
        // reset in mid-run
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        @(posedge i_sys_clk);
        chk("mid reset", {fetch_addr, 30'h0, t_flag, retire}, 64'h0);
        chk("mid reset product", {prod_hi, prod_lo}, 64'h0);
        i_rst <= 1'b0;
        // first load and store after release start from the reset state
        step(16'h3A05);
        step(16'hAA26);
        chk("wdata", last_wdata, 64'h5);
        chk("fetch_addr", fetch_addr, 32'h4);
        $display("test mid reset done");
        summarize();
    end
endmodule : rsc_core_tb
